/* File: rtl/bus_xcvr_pkg.sv */
package bus_xcvr_pkg;

  // Register byte addresses
  localparam logic [6:0] CTRL_ADDR = 7'h20;
  localparam logic [6:0] STAT_ADDR = 7'h22;
  // Address window of the selective wake configuration registers
  localparam logic [6:0] PN_CFG_LO = 7'h26;
  localparam logic [6:0] PN_CFG_HI = 7'h2f;

  // Control register field positions
  localparam int CTRL_FD_BIT = 6;
  localparam int CTRL_PNOK_BIT = 5;
  localparam int CTRL_PNEN_BIT = 4;
  localparam int CTRL_MODE_LSB = 0;

  // Status register field positions
  localparam int STAT_TXRDY_BIT = 7;
  localparam int STAT_PNERR_BIT = 6;
  localparam int STAT_PNOK_BIT = 5;
  localparam int STAT_OSC_BIT = 4;
  localparam int STAT_SILENT_BIT = 3;
  localparam int STAT_SUPLOW_BIT = 1;
  localparam int STAT_TXTO_BIT = 0;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic REG_EN_RESET = 1'b1;

  // Transceiver mode encodings
  localparam logic [1:0] XMODE_OFFLINE = 2'h0;
  localparam logic [1:0] XMODE_ACT_UV = 2'h1;
  localparam logic [1:0] XMODE_ACT = 2'h2;
  localparam logic [1:0] XMODE_LISTEN = 2'h3;

  // Device mode encodings
  localparam logic [2:0] DMODE_NORMAL = 3'h7;
  localparam logic [2:0] DMODE_SLEEP = 3'h1;
  localparam logic [2:0] DMODE_STANDBY = 3'h4;

  // SPI frame: 7 address bits, read flag, 8 data bits
  localparam logic [4:0] SPI_HDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;

  // Timing, in microseconds, and clock rate
  localparam int CLK_MHZ = 125;
  localparam int T_WAKE_DOM_US = 5;
  localparam int T_WAKE_REC_US = 5;
  localparam int T_TO_WAKE_US = 1000;
  localparam int T_TO_SILENCE_US = 1000;
  localparam int T_TO_TXDOM_US = 2000;

  // Cycle counts (whole microseconds give exact counts)
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] WAKE_DOM_CYC = CNT_W'(T_WAKE_DOM_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] WAKE_REC_CYC = CNT_W'(T_WAKE_REC_US * CLK_MHZ);
  localparam int WAKE_TO_CYC = T_TO_WAKE_US * CLK_MHZ;
  localparam int SILENCE_CYC = T_TO_SILENCE_US * CLK_MHZ;
  localparam int TXDOM_CYC = T_TO_TXDOM_US * CLK_MHZ;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps

// Three-stage pin synchroniser; the level moves only when stages two and three agree
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Capture chain; first stage feeds only the second
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accepted level plus one-cycle edge pulses
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      level_out <= INIT;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else
    begin
      rise_out <= (s2_r == s3_r) && s3_r && !level_out;
      fall_out <= (s2_r == s3_r) && !s3_r && level_out;
      if (s2_r == s3_r)
      begin
        level_out <= s3_r;
      end
    end
  end

endmodule

/* File: rtl/bus_xcvr_wake.sv */
`timescale 1ns/1ps

// Contract
// - Watch for wake pattern when offline, enabled, unselective
// - Dominant-recessive-dominant within time-out; extra pulses tolerated after the first dominant phase
// - Each phase must last its minimum
// - Valid pattern sets bus wake flag
// - Valid pattern drives receive output low
// - Wake from Sleep enables regulator, requests Standby
// - Control bit 6 enables FD tolerance
// - Control bit 5 holds configuration-valid
// - Control bit 4 enables selective wake-up
// - Control bits 1:0 choose mode in Normal
// - Status bit 7 shows transmitter ready
// - Status bit 6 is error or not-valid
// - Status bit 5 mirrors configuration-valid
// - Status bit 4 shows oscillator locked
// - Status bit 3 shows bus silent
// - Status bit 1 shows supply undervoltage
// - Status bit 0 shows transmit time-out
// - Standby or Sleep forces offline
// - Held-low transmit input blocks active, listen instead
// - Configuration write clears configuration-valid
// - Ignore wake patterns unless offline and enabled
module bus_xcvr_wake #(
  parameter int WAKE_TO_CYC = bus_xcvr_pkg::WAKE_TO_CYC,
  parameter int SILENCE_CYC = bus_xcvr_pkg::SILENCE_CYC,
  parameter int TXDOM_CYC = bus_xcvr_pkg::TXDOM_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic SPI_SCK_IN,
  input wire logic SPI_NCS_IN,
  input wire logic SPI_SDI_IN,
  output logic SPI_SDO_OUT,
  output logic SPI_SDO_EN_OUT,
  input wire logic BUS_RX_IN,
  input wire logic TX_DATA_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire logic PN_OSC_LOCKED_IN,
  input wire logic [2:0] DEVICE_MODE_SELECT_IN,
  input wire logic BUS_WAKE_ENABLE_IN,
  input wire logic FRAME_DETECT_ERROR_FLAG_IN,
  input wire logic BUS_WAKE_CLEAR_IN,
  output logic BUS_WAKE_FLAG_OUT,
  output logic RX_DATA_OUT,
  output logic REGULATOR_ENABLE_OUT,
  output logic STANDBY_REQ_OUT,
  output logic [1:0] XCVR_MODE_OUT,
  output logic TX_ENABLE_OUT,
  output logic FD_TOLERANCE_ENABLE_OUT,
  output logic SELECTIVE_WAKE_ENABLE_OUT
);

  typedef enum logic [1:0] {W_IDLE, W_DOM1, W_REC, W_DOM2} wake_st_t;
  typedef enum logic [1:0] {X_OFF, X_LISTEN, X_ACTIVE} xcvr_st_t;

  localparam int CW = bus_xcvr_pkg::CNT_W;
  localparam logic [CW-1:0] WAKE_TO = CW'(WAKE_TO_CYC);
  localparam logic [CW-1:0] SILENCE = CW'(SILENCE_CYC);
  localparam logic [CW-1:0] TXDOM = CW'(TXDOM_CYC);

  // Synchronised pin levels and edges
  logic sck_rise;
  logic sck_fall;
  logic ncs_lvl;
  logic sdi_lvl;
  logic rx_lvl;
  logic rx_rise;
  logic rx_fall;
  logic txd_lvl;
  logic suplow_lvl;
  logic osc_lvl;

  pin_sync #(.INIT(1'b0)) u_sck (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN), .pin_in(SPI_SCK_IN),
    .level_out(), .rise_out(sck_rise), .fall_out(sck_fall));
  pin_sync #(.INIT(1'b1)) u_ncs (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN), .pin_in(SPI_NCS_IN),
    .level_out(ncs_lvl), .rise_out(), .fall_out());
  pin_sync #(.INIT(1'b0)) u_sdi (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN), .pin_in(SPI_SDI_IN),
    .level_out(sdi_lvl), .rise_out(), .fall_out());
  pin_sync #(.INIT(1'b1)) u_rx (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN), .pin_in(BUS_RX_IN),
    .level_out(rx_lvl), .rise_out(rx_rise), .fall_out(rx_fall));
  pin_sync #(.INIT(1'b1)) u_txd (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN), .pin_in(TX_DATA_IN),
    .level_out(txd_lvl), .rise_out(), .fall_out());
  pin_sync #(.INIT(1'b0)) u_uv (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN), .pin_in(SUPPLY_LOW_IN),
    .level_out(suplow_lvl), .rise_out(), .fall_out());
  pin_sync #(.INIT(1'b0)) u_osc (.clk_in(SYS_CLK_IN), .nrst_in(NRST_IN),
    .pin_in(PN_OSC_LOCKED_IN), .level_out(osc_lvl), .rise_out(), .fall_out());

  // SPI state
  logic [4:0] bit_cnt_r; // Bits taken in this frame
  logic [15:0] shift_in_r; // Incoming frame
  logic [7:0] sdo_sh_r; // Outgoing read data
  logic [7:0] rd_data; // Read mux
  logic wr_stb; // Full write frame taken
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  // Control and status state
  logic [7:0] ctrl_r;
  logic [7:0] status;
  xcvr_st_t xst_r;
  xcvr_st_t xst_nxt;
  logic txto_r; // Transmit input dominant too long
  logic [CW-1:0] txcnt_r;
  logic silent_r;
  logic [CW-1:0] silcnt_r;

  // Wake filter state
  wake_st_t wst_r;
  logic [CW-1:0] phase_r; // Length of current level run
  logic [CW-1:0] window_r; // Time since the pattern started
  logic monitor; // Wake detection armed
  logic wake_hit; // One-cycle valid pattern
  logic rx_dom; // Bus dominant (receiver reads low)
  logic dev_low; // Device in Standby or Sleep

  assign rx_dom = !rx_lvl;
  assign dev_low = DEVICE_MODE_SELECT_IN != bus_xcvr_pkg::DMODE_NORMAL;
  assign wr_addr = shift_in_r[14:8];
  assign wr_data = {shift_in_r[6:0], sdi_lvl};
  // Write frame ends on the 16th rising clock with the read flag clear
  assign wr_stb = sck_rise && !ncs_lvl && bit_cnt_r == bus_xcvr_pkg::SPI_FRAME_LAST
    && !shift_in_r[7];

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb
  begin
    rd_data = 8'h00;
    if (shift_in_r[6:0] == bus_xcvr_pkg::CTRL_ADDR)
    begin
      rd_data = ctrl_r;
    end
    else if (shift_in_r[6:0] == bus_xcvr_pkg::STAT_ADDR)
    begin
      rd_data = status;
    end
  end

  // SPI receive side: sample on rising clock, frame restarts when select rises
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      bit_cnt_r <= 5'h00;
      shift_in_r <= 16'h0000;
    end
    else if (ncs_lvl)
    begin
      bit_cnt_r <= 5'h00;
    end
    else if (sck_rise)
    begin
      shift_in_r <= {shift_in_r[14:0], sdi_lvl};
      // Bit count holds at 31, so extra clocks beyond that never wrap it
      if (bit_cnt_r != 5'h1f)
      begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // SPI transmit side: data loaded after the header, shifted on falling clock
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      sdo_sh_r <= 8'h00;
      SPI_SDO_OUT <= 1'b0;
      SPI_SDO_EN_OUT <= 1'b0;
    end
    else
    begin
      SPI_SDO_EN_OUT <= !ncs_lvl;
      if (sck_rise && bit_cnt_r == bus_xcvr_pkg::SPI_HDR_LAST)
      begin
        sdo_sh_r <= rd_data;
      end
      else if (sck_fall && bit_cnt_r > bus_xcvr_pkg::SPI_HDR_LAST)
      begin
        SPI_SDO_OUT <= sdo_sh_r[7];
        sdo_sh_r <= {sdo_sh_r[6:0], 1'b0};
      end
    end
  end

  // Control register; reserved bits never store
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      ctrl_r <= bus_xcvr_pkg::CTRL_RESET;
    end
    else if (wr_stb && wr_addr == bus_xcvr_pkg::CTRL_ADDR)
    begin
      ctrl_r <= wr_data & 8'h73;
    end
    else if (wr_stb && wr_addr >= bus_xcvr_pkg::PN_CFG_LO && wr_addr <= bus_xcvr_pkg::PN_CFG_HI)
    begin
      ctrl_r[bus_xcvr_pkg::CTRL_PNOK_BIT] <= 1'b0;
    end
  end

  // Status assembly, read live
  always_comb
  begin
    status = 8'h00;
    status[bus_xcvr_pkg::STAT_TXRDY_BIT] = xst_r == X_ACTIVE && !txto_r;
    status[bus_xcvr_pkg::STAT_PNERR_BIT] = FRAME_DETECT_ERROR_FLAG_IN
      || !ctrl_r[bus_xcvr_pkg::CTRL_PNOK_BIT];
    status[bus_xcvr_pkg::STAT_PNOK_BIT] = ctrl_r[bus_xcvr_pkg::CTRL_PNOK_BIT];
    status[bus_xcvr_pkg::STAT_OSC_BIT] = osc_lvl;
    status[bus_xcvr_pkg::STAT_SILENT_BIT] = silent_r;
    status[bus_xcvr_pkg::STAT_SUPLOW_BIT] = suplow_lvl;
    status[bus_xcvr_pkg::STAT_TXTO_BIT] = txto_r;
  end

  // Transceiver mode choice
  always_comb
  begin
    xst_nxt = X_OFF;
    if (dev_low)
    begin
      xst_nxt = X_OFF;
    end
    else
    begin
      unique case (ctrl_r[1:0])
        bus_xcvr_pkg::XMODE_OFFLINE: xst_nxt = X_OFF;
        bus_xcvr_pkg::XMODE_LISTEN: xst_nxt = X_LISTEN;
        bus_xcvr_pkg::XMODE_ACT_UV, bus_xcvr_pkg::XMODE_ACT:
        begin
          // Supervised active mode drops offline under undervoltage
          if (ctrl_r[1:0] == bus_xcvr_pkg::XMODE_ACT_UV && suplow_lvl)
          begin
            xst_nxt = X_OFF;
          end
          // Never step into active while the transmit input is low
          else if (xst_r == X_ACTIVE || txd_lvl)
          begin
            xst_nxt = X_ACTIVE;
          end
          else
          begin
            xst_nxt = X_LISTEN;
          end
        end
      endcase
    end
  end

  // Transceiver state and its outputs
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      xst_r <= X_OFF;
      XCVR_MODE_OUT <= bus_xcvr_pkg::XMODE_OFFLINE;
      TX_ENABLE_OUT <= 1'b0;
      FD_TOLERANCE_ENABLE_OUT <= 1'b0;
      SELECTIVE_WAKE_ENABLE_OUT <= 1'b0;
    end
    else
    begin
      xst_r <= xst_nxt;
      XCVR_MODE_OUT <= xst_nxt == X_ACTIVE ? bus_xcvr_pkg::XMODE_ACT :
        xst_nxt == X_LISTEN ? bus_xcvr_pkg::XMODE_LISTEN : bus_xcvr_pkg::XMODE_OFFLINE;
      TX_ENABLE_OUT <= xst_nxt == X_ACTIVE && !txto_r;
      FD_TOLERANCE_ENABLE_OUT <= ctrl_r[bus_xcvr_pkg::CTRL_FD_BIT];
      SELECTIVE_WAKE_ENABLE_OUT <= ctrl_r[bus_xcvr_pkg::CTRL_PNEN_BIT];
    end
  end

  // Transmit dominant time-out; released once the input returns high
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      txcnt_r <= '0;
      txto_r <= 1'b0;
    end
    else if (txd_lvl || xst_r != X_ACTIVE)
    begin
      txcnt_r <= '0;
      txto_r <= txto_r && !txd_lvl;
    end
    else if (txcnt_r == TXDOM - 1'b1)
    begin
      txto_r <= 1'b1;
    end
    else
    begin
      txcnt_r <= txcnt_r + 1'b1;
    end
  end

  // Bus silence: any edge restarts the count
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      silcnt_r <= '0;
      silent_r <= 1'b0;
    end
    else if (rx_rise || rx_fall)
    begin
      silcnt_r <= '0;
      silent_r <= 1'b0;
    end
    else if (silcnt_r == SILENCE - 1'b1)
    begin
      silent_r <= 1'b1;
    end
    else
    begin
      silcnt_r <= silcnt_r + 1'b1;
    end
  end

  // Armed only offline, enabled, and with selective wake off or unconfigured
  assign monitor = xst_r == X_OFF && BUS_WAKE_ENABLE_IN
    && (!ctrl_r[bus_xcvr_pkg::CTRL_PNEN_BIT] || !ctrl_r[bus_xcvr_pkg::CTRL_PNOK_BIT]);
  // Pattern completes on the last cycle of the second dominant minimum
  assign wake_hit = wst_r == W_DOM2 && rx_dom
    && phase_r == bus_xcvr_pkg::WAKE_DOM_CYC - 1'b1;

  // Wake filter; short glitches restart the current phase run, except in the first dominant phase, where they return to idle
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      wst_r <= W_IDLE;
      phase_r <= '0;
      window_r <= '0;
    end
    else if (!monitor)
    begin
      wst_r <= W_IDLE;
      phase_r <= '0;
      window_r <= '0;
    end
    else if (wst_r != W_IDLE && window_r == WAKE_TO - 1'b1)
    begin
      wst_r <= W_IDLE;
      phase_r <= '0;
      window_r <= '0;
    end
    else
    begin
      if (wst_r != W_IDLE)
      begin
        window_r <= window_r + 1'b1;
      end
      unique case (wst_r)
        W_IDLE:
        begin
          // The window opens with the first dominant level
          if (rx_dom)
          begin
            wst_r <= W_DOM1;
            phase_r <= '0;
            window_r <= '0;
          end
        end
        W_DOM1:
        begin
          if (!rx_dom)
          begin
            wst_r <= W_IDLE;
            phase_r <= '0;
          end
          else if (phase_r == bus_xcvr_pkg::WAKE_DOM_CYC - 1'b1)
          begin
            wst_r <= W_REC;
            phase_r <= '0;
          end
          else
          begin
            phase_r <= phase_r + 1'b1;
          end
        end
        W_REC:
        begin
          // A dominant pulse restarts the recessive run but keeps progress
          if (rx_dom)
          begin
            phase_r <= '0;
          end
          else if (phase_r == bus_xcvr_pkg::WAKE_REC_CYC - 1'b1)
          begin
            wst_r <= W_DOM2;
            phase_r <= '0;
          end
          else
          begin
            phase_r <= phase_r + 1'b1;
          end
        end
        W_DOM2:
        begin
          if (!rx_dom)
          begin
            phase_r <= '0;
          end
          else if (wake_hit)
          begin
            wst_r <= W_IDLE;
            phase_r <= '0;
            window_r <= '0;
          end
          else
          begin
            phase_r <= phase_r + 1'b1;
          end
        end
      endcase
    end
  end

  // Wake flag (set beats clear), receive output and regulator handling
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      BUS_WAKE_FLAG_OUT <= 1'b0;
      RX_DATA_OUT <= 1'b1;
      REGULATOR_ENABLE_OUT <= bus_xcvr_pkg::REG_EN_RESET;
      STANDBY_REQ_OUT <= 1'b0;
    end
    else
    begin
      BUS_WAKE_FLAG_OUT <= wake_hit || (BUS_WAKE_FLAG_OUT && !BUS_WAKE_CLEAR_IN);
      // Offline, the receive pin tells the host about a pending wake
      if (xst_r == X_OFF)
      begin
        RX_DATA_OUT <= !(wake_hit || BUS_WAKE_FLAG_OUT) && !(BUS_WAKE_CLEAR_IN == 1'b0
          && BUS_WAKE_FLAG_OUT);
      end
      else
      begin
        RX_DATA_OUT <= rx_lvl;
      end
      STANDBY_REQ_OUT <= wake_hit && DEVICE_MODE_SELECT_IN == bus_xcvr_pkg::DMODE_SLEEP;
      if (wake_hit && DEVICE_MODE_SELECT_IN == bus_xcvr_pkg::DMODE_SLEEP)
      begin
        REGULATOR_ENABLE_OUT <= 1'b1;
      end
      else if (DEVICE_MODE_SELECT_IN == bus_xcvr_pkg::DMODE_SLEEP && !BUS_WAKE_FLAG_OUT)
      begin
        // Sleep with no pending wake lets the regulators drop
        REGULATOR_ENABLE_OUT <= 1'b0;
      end
    end
  end

endmodule

/* File: dv/bus_xcvr_monitor.sv */
`timescale 1ns/1ps
// Property checker on wake, mode and regulator pins; sees top ports only
module bus_xcvr_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic BUS_RX_IN,
  input wire logic TX_DATA_IN,
  input wire logic [2:0] DEVICE_MODE_SELECT_IN,
  input wire logic BUS_WAKE_ENABLE_IN,
  input wire logic BUS_WAKE_CLEAR_IN,
  input wire logic BUS_WAKE_FLAG_OUT,
  input wire logic RX_DATA_OUT,
  input wire logic REGULATOR_ENABLE_OUT,
  input wire logic STANDBY_REQ_OUT,
  input wire logic [1:0] XCVR_MODE_OUT
);
  // Dominant run length at the raw pin; saturates so it never wraps
  logic [9:0] dom_run_r;

  // Count dominant cycles, restart on any recessive cycle
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      dom_run_r <= 10'h000;
    else if (BUS_RX_IN)
      dom_run_r <= 10'h000;
    else if (dom_run_r != 10'h3ff)
      dom_run_r <= dom_run_r + 10'h001;
  end

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  flag_hold_a: assert property (
    BUS_WAKE_FLAG_OUT && !BUS_WAKE_CLEAR_IN |=> BUS_WAKE_FLAG_OUT)
    else $error("wake flag dropped without clear");
  // Synchroniser lag means the run is a little over the minimum
  dom_len_a: assert property (
    $rose(BUS_WAKE_FLAG_OUT) |-> dom_run_r >= 10'h26c)
    else $error("wake flag without a full dominant phase");
  wake_gate_a: assert property (
    $rose(BUS_WAKE_FLAG_OUT) |-> $past(BUS_WAKE_ENABLE_IN)
      && $past(XCVR_MODE_OUT) == bus_xcvr_pkg::XMODE_OFFLINE)
    else $error("wake flag while not armed");
  rx_low_a: assert property (
    $rose(BUS_WAKE_FLAG_OUT) && XCVR_MODE_OUT == bus_xcvr_pkg::XMODE_OFFLINE
      |-> ##[0:1] !RX_DATA_OUT)
    else $error("receive output not low on wake");
  standby_pulse_a: assert property (
    STANDBY_REQ_OUT |=> !STANDBY_REQ_OUT)
    else $error("standby request longer than one cycle");
  standby_cause_a: assert property (
    STANDBY_REQ_OUT |-> ($past(DEVICE_MODE_SELECT_IN) == bus_xcvr_pkg::DMODE_SLEEP)
      ##[0:1] REGULATOR_ENABLE_OUT)
    else $error("standby request outside sleep or regulator off");
  reg_drop_a: assert property (
    $fell(REGULATOR_ENABLE_OUT) |-> !$past(BUS_WAKE_FLAG_OUT)
      && $past(DEVICE_MODE_SELECT_IN) == bus_xcvr_pkg::DMODE_SLEEP)
    else $error("regulator dropped outside sleep");
  offline_forced_a: assert property (
    (DEVICE_MODE_SELECT_IN != bus_xcvr_pkg::DMODE_NORMAL)[*3]
      |-> XCVR_MODE_OUT == bus_xcvr_pkg::XMODE_OFFLINE)
    else $error("transceiver not offline outside normal");
  // Eight low cycles cover the pin synchroniser depth
  no_active_a: assert property (
    (!TX_DATA_IN)[*8] ##1 (XCVR_MODE_OUT == bus_xcvr_pkg::XMODE_ACT)
      |-> $past(XCVR_MODE_OUT) == bus_xcvr_pkg::XMODE_ACT)
    else $error("active entered with transmit input low");

  wake_c: cover property ($rose(BUS_WAKE_FLAG_OUT));
  standby_c: cover property (STANDBY_REQ_OUT);
  active_c: cover property (XCVR_MODE_OUT == bus_xcvr_pkg::XMODE_ACT);
endmodule

/* File: dv/can_node_model.sv */
`timescale 1ns/1ps
// Remote bus node: drives the receiver level seen by the transceiver
module can_node_model (
  input wire logic clk_in,
  output logic rx_out
);
  // Idle recessive; bus termination holds it there between frames
  initial rx_out = 1'b1;

  // Hold one bus level for n clocks; call just after a rising edge
  task automatic hold(input logic lvl, input int n);
    rx_out <= lvl;
    repeat (n) @(posedge clk_in);
  endtask

  // Dominant, recessive, dominant; optional short dominant pulse mid-recessive
  task automatic wake(input int d1, input int r, input int d2, input int g);
    hold(1'b0, d1);
    if (g > 0)
    begin
      hold(1'b1, r / 2);
      hold(1'b0, g);
      hold(1'b1, r / 2);
    end
    else
      hold(1'b1, r);
    hold(1'b0, d2);
    hold(1'b1, 1);
  endtask
endmodule

/* File: dv/tb_bus_xcvr_wake.sv */
`timescale 1ns/1ps
// Self-checking bench: register frames, transceiver modes, bus wake patterns
module tb_bus_xcvr_wake;
  logic sys_clk, nrst, sck, ncs, sdi, rx_line, txd, sup_low, osc_ok, fde, wake_en, wake_clr;
  logic sdo, sdo_en, flag, rxd, reg_en, stb_req, tx_en, fd_en, sel_en, saw_stb;
  logic [2:0] dev_mode;
  logic [1:0] xmode;
  logic [7:0] d;
  int num_errors = 0;
  int num_checks = 0;
  int ctrl_m = 0; // Bench copy of the control register
  // Wake table: ctrl, enable, dom, rec, dom, glitch, flag expected
  int rows [9][7] = '{'{0, 1, 700, 700, 700, 0, 1}, '{0, 1, 300, 700, 700, 0, 0},
    '{0, 1, 700, 300, 700, 0, 0}, '{0, 1, 700, 1400, 700, 60, 1},
    '{0, 1, 700, 2500, 700, 0, 0}, '{0, 0, 700, 700, 700, 0, 0},
    '{2, 1, 700, 700, 700, 0, 0}, '{48, 1, 700, 700, 700, 0, 0},
    '{16, 1, 700, 700, 700, 0, 1}};
  // Data-out wire is pulled high when the block releases it
  wire miso = sdo_en ? sdo : 1'b1;

  bus_xcvr_wake #(.WAKE_TO_CYC(3000), .SILENCE_CYC(200), .TXDOM_CYC(200)) bus_xcvr_wake_inst (
    .SYS_CLK_IN(sys_clk), .NRST_IN(nrst), .SPI_SCK_IN(sck), .SPI_NCS_IN(ncs),
    .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo), .SPI_SDO_EN_OUT(sdo_en), .BUS_RX_IN(rx_line),
    .TX_DATA_IN(txd), .SUPPLY_LOW_IN(sup_low), .PN_OSC_LOCKED_IN(osc_ok),
    .DEVICE_MODE_SELECT_IN(dev_mode), .BUS_WAKE_ENABLE_IN(wake_en),
    .FRAME_DETECT_ERROR_FLAG_IN(fde), .BUS_WAKE_CLEAR_IN(wake_clr),
    .BUS_WAKE_FLAG_OUT(flag), .RX_DATA_OUT(rxd), .REGULATOR_ENABLE_OUT(reg_en),
    .STANDBY_REQ_OUT(stb_req), .XCVR_MODE_OUT(xmode), .TX_ENABLE_OUT(tx_en),
    .FD_TOLERANCE_ENABLE_OUT(fd_en), .SELECTIVE_WAKE_ENABLE_OUT(sel_en));
  can_node_model can_node_model_inst (.clk_in(sys_clk), .rx_out(rx_line));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // The standby request lasts one cycle, so keep a sticky copy, cleared by reset
  always @(posedge sys_clk)
    saw_stb <= (nrst === 1'b1) && (saw_stb === 1'b1 || stb_req === 1'b1);

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    if (got !== exp)
      num_errors++;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    if (got !== exp)
      num_errors++;
  endtask

  // One frame: address, read flag, data, MSB first; SCK half period 8 clocks
  task automatic spi(input logic [6:0] a, input logic rw, input logic [7:0] wd,
                     output logic [7:0] q);
    logic [15:0] f;
    f = {a, rw, wd};
    q = 8'h00;
    @(posedge sys_clk) ncs <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi <= f[i];
      tick(8);
      sck <= 1'b1;
      if (i < 8)
        q = {q[6:0], miso};
      tick(8);
      sck <= 1'b0;
    end
    tick(8);
    ncs <= 1'b1;
    tick(8);
  endtask

  // Write and keep the bench copy in step; config writes drop the valid bit
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] q;
    spi(a, 1'b0, v, q);
    if (a == bus_xcvr_pkg::CTRL_ADDR)
      ctrl_m = v & 8'h73;
    if (a >= bus_xcvr_pkg::PN_CFG_LO && a <= bus_xcvr_pkg::PN_CFG_HI)
      ctrl_m = ctrl_m & 8'h53;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    spi(a, 1'b1, 8'h00, q);
    chk8(q, exp, "register read");
  endtask

  // Transceiver mode the bench expects from its own inputs
  function automatic logic [1:0] xm_m();
    if (dev_mode != bus_xcvr_pkg::DMODE_NORMAL)
      return 2'h0;
    case (ctrl_m[1:0])
      2'h0: return 2'h0;
      2'h1: return sup_low ? 2'h0 : (txd ? 2'h2 : 2'h3);
      2'h2: return txd ? 2'h2 : 2'h3;
      default: return 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] stat_m(input logic silent, input logic txto, input logic rdy);
    return {rdy, fde | ~ctrl_m[5], ctrl_m[5], osc_ok, silent, 1'b0, sup_low, txto};
  endfunction

  task automatic chk_mode();
    chk8({6'h00, xmode}, {6'h00, xm_m()}, "mode");
    chk1(tx_en, xm_m() == 2'h2, "tx enable");
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cut a hang short well after the expected run of about 65000 clocks
  initial
  begin
    tick(90000);
    num_errors++;
    final_report();
  end

  initial
  begin
    {sck, sdi, sup_low, osc_ok, fde, wake_en, wake_clr, nrst} = '0;
    {ncs, txd} = 2'h3;
    dev_mode = bus_xcvr_pkg::DMODE_NORMAL;
    void'($urandom(32'h4373));
    tick(20);
    nrst <= 1'b1;
    tick(300);
    rd_chk(bus_xcvr_pkg::CTRL_ADDR, bus_xcvr_pkg::CTRL_RESET);
    chk1(reg_en, bus_xcvr_pkg::REG_EN_RESET, "regulator");
    // Every mode code with and without undervoltage, random upper bits and random error and oscillator inputs
    for (int i = 0; i < 8; i++)
    begin
      sup_low <= i[2];
      fde <= 1'($urandom);
      osc_ok <= 1'($urandom);
      d = 8'($urandom);
      wr(bus_xcvr_pkg::CTRL_ADDR, {d[7:2], 2'(i)});
      rd_chk(bus_xcvr_pkg::CTRL_ADDR, 8'(ctrl_m));
      chk1(fd_en, ctrl_m[6], "fd tolerance");
      chk1(sel_en, ctrl_m[4], "selective wake");
      chk_mode();
      rd_chk(bus_xcvr_pkg::STAT_ADDR, stat_m(1, 0, xm_m() == 2'h2));
    end
    sup_low <= 1'b0;
    // Config write, read-only and unmapped places
    wr(bus_xcvr_pkg::CTRL_ADDR, 8'h20);
    wr(bus_xcvr_pkg::PN_CFG_LO, 8'h5a);
    wr(bus_xcvr_pkg::STAT_ADDR, 8'hff);
    wr(7'h30, 8'hff);
    rd_chk(7'h30, 8'h00);
    rd_chk(bus_xcvr_pkg::CTRL_ADDR, 8'(ctrl_m));
    rd_chk(bus_xcvr_pkg::STAT_ADDR, stat_m(1, 0, 1'b0));
    // Transmit input held low blocks active, long low trips the time-out
    txd <= 1'b0;
    wr(bus_xcvr_pkg::CTRL_ADDR, 8'h02);
    chk_mode();
    txd <= 1'b1;
    tick(10);
    chk_mode();
    txd <= 1'b0;
    tick(250);
    chk1(tx_en, 1'b0, "tx after time-out");
    rd_chk(bus_xcvr_pkg::STAT_ADDR, stat_m(1, 1, 1'b0));
    txd <= 1'b1;
    tick(10);
    rd_chk(bus_xcvr_pkg::STAT_ADDR, stat_m(1, 0, 1'b1));
    dev_mode <= bus_xcvr_pkg::DMODE_STANDBY;
    tick(10);
    chk_mode();
    dev_mode <= bus_xcvr_pkg::DMODE_NORMAL;
    // Wake table; the long pause lets any half-seen pattern expire
    foreach (rows[r])
    begin
      wr(bus_xcvr_pkg::CTRL_ADDR, 8'(rows[r][0]));
      wake_en <= rows[r][1][0];
      tick(50);
      can_node_model_inst.wake(rows[r][2], rows[r][3], rows[r][4], rows[r][5]);
      tick(20);
      chk1(flag, rows[r][6][0], "wake flag");
      chk1(rxd, !rows[r][6][0], "receive output");
      wake_clr <= 1'b1;
      tick(1);
      wake_clr <= 1'b0;
      tick(3100);
    end
    // A short burst makes the bus look active
    can_node_model_inst.hold(1'b0, 20);
    can_node_model_inst.hold(1'b1, 1);
    rd_chk(bus_xcvr_pkg::STAT_ADDR, stat_m(0, 0, 1'b0));
    // Sleep: regulator off, a wake turns it on and asks for standby
    wr(bus_xcvr_pkg::CTRL_ADDR, 8'h02);
    dev_mode <= bus_xcvr_pkg::DMODE_SLEEP;
    chk1(saw_stb, 1'b0, "early standby request");
    tick(20);
    chk1(reg_en, 1'b0, "regulator in sleep");
    chk_mode();
    can_node_model_inst.wake(700, 700, 700, 0);
    tick(20);
    chk1(flag, 1'b1, "sleep wake flag");
    chk1(reg_en, 1'b1, "regulator on wake");
    chk1(saw_stb, 1'b1, "standby request");
    dev_mode <= bus_xcvr_pkg::DMODE_STANDBY;
    tick(10);
    final_report();
  end
endmodule

bind bus_xcvr_wake bus_xcvr_monitor bus_xcvr_monitor_inst (
  .SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN), .BUS_RX_IN(BUS_RX_IN),
  .TX_DATA_IN(TX_DATA_IN), .DEVICE_MODE_SELECT_IN(DEVICE_MODE_SELECT_IN),
  .BUS_WAKE_ENABLE_IN(BUS_WAKE_ENABLE_IN), .BUS_WAKE_CLEAR_IN(BUS_WAKE_CLEAR_IN),
  .BUS_WAKE_FLAG_OUT(BUS_WAKE_FLAG_OUT), .RX_DATA_OUT(RX_DATA_OUT),
  .REGULATOR_ENABLE_OUT(REGULATOR_ENABLE_OUT), .STANDBY_REQ_OUT(STANDBY_REQ_OUT),
  .XCVR_MODE_OUT(XCVR_MODE_OUT));
